//--- sli_panel.sv
// shared line-serial monochrome panel: pixel store and pin logic
// assumes mclk is free running and the serial clock is at most 1.1 MHz
`timescale 1ns/1ps
`default_nettype none
`include "sli_params.svh"

// Operation
// - Serial bits are taken only while the select pin is high, each on the serial clock.
// - Data arrives only as whole lines of 128 bits, never as single pixels.
// - The panel holds a square 128 by 128 array of one-bit light or dark pixels.
// - Written pixels stay stored and shown with no periodic rewrite.
module sli_panel #(
  parameter int unsigned POL_TIMEOUT_CYC = `SLI_POL_TIMEOUT_CYC
) (
  input  wire logic                       mclk,
  input  wire logic                       resetn,
  input  wire logic                       ce,
  input  wire logic                       display_serial_clock,
  input  wire logic                       display_select,
  input  wire logic                       display_serial_in,
  input  wire logic                       display_polarity_toggle,
  input  wire logic                       display_owner_select,
  input  wire logic [`SLI_ADDR_BITS-1:0]  pixel_rd_row,
  output var  logic [`SLI_LINE_BITS-1:0]  pixel_rd_data,
  output var  logic [`SLI_ROWS-1:0]       row_written,
  output var  logic [15:0]                lines_written,
  output var  logic                       line_commit,
  output var  logic                       panel_polarity,
  output var  logic                       polarity_stale,
  output var  logic                       owner_is_app,
  output var  logic                       link_busy
);

  // ----------------------------------------------------------------
  // link domain
  // ----------------------------------------------------------------
  logic [`SLI_ADDR_BITS-1:0] link_row;
  logic [`SLI_LINE_BITS-1:0] link_data;
  logic                      link_tgl;

  sli_line_rx u_rx (
    .display_serial_clock (display_serial_clock),
    .resetn               (resetn),
    .display_select       (display_select),
    .display_serial_in    (display_serial_in),
    .line_row_q           (link_row),
    .line_data_q          (link_data),
    .line_tgl_q           (link_tgl)
  );

  // ----------------------------------------------------------------
  // synchronisers
  // ----------------------------------------------------------------
  wire  logic [`SLI_SY_WIDTH-1:0] sy_in = {display_select, display_owner_select,
                                           display_polarity_toggle, link_tgl};
  logic [`SLI_SY_WIDTH-1:0]       sy_meta_q;
  logic [`SLI_SY_WIDTH-1:0]       sy_q;

  genvar gi;
  generate
    for (gi = 0; gi < `SLI_SY_WIDTH; gi++) begin : g_sync
      always_ff @(posedge mclk) begin
        if (!resetn) begin
          sy_meta_q[gi] <= 1'b0;
          sy_q[gi]      <= 1'b0;
        end else if (ce) begin
          sy_meta_q[gi] <= sy_in[gi];
          sy_q[gi]      <= sy_meta_q[gi];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // edge detection
  // ----------------------------------------------------------------
  logic line_seen_q;
  logic pol_seen_q;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      line_seen_q <= 1'b0;
      pol_seen_q  <= 1'b0;
    end else if (ce) begin
      line_seen_q <= sy_q[`SLI_SY_LINE];
      pol_seen_q  <= sy_q[`SLI_SY_POL];
    end
  end

  // a line is ready each time the link toggle flips
  wire logic line_evt = ce && (sy_q[`SLI_SY_LINE] != line_seen_q);
  // one pulse on the pin counts once, on its rising edge
  wire logic pol_evt  = ce && sy_q[`SLI_SY_POL] && !pol_seen_q;

  // ----------------------------------------------------------------
  // commit sequencer
  // ----------------------------------------------------------------
  sli_pkg::sli_state_e st_q;
  sli_pkg::sli_state_e st_d;

  always_comb begin
    case (st_q)
      sli_pkg::SLI_ST_IDLE: begin
        st_d = line_evt ? sli_pkg::SLI_ST_COMMIT : sli_pkg::SLI_ST_IDLE;
      end
      sli_pkg::SLI_ST_COMMIT: begin
        st_d = sli_pkg::SLI_ST_IDLE;
      end
      default: begin
        st_d = sli_pkg::SLI_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      st_q <= sli_pkg::SLI_ST_IDLE;
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  // link data is stable well before and after the toggle edge arrives
  wire logic do_write = ce && (st_q == sli_pkg::SLI_ST_COMMIT);

  // ----------------------------------------------------------------
  // pixel store
  // ----------------------------------------------------------------
  // one bit per pixel, a whole row per write; nothing refreshes it
  sli_pkg::sli_line_t pix_mem [`SLI_ROWS];

  always_ff @(posedge mclk) begin
    if (do_write) begin
      pix_mem[link_row] <= link_data;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      pixel_rd_data <= '0;
    end else if (ce) begin
      pixel_rd_data <= pix_mem[pixel_rd_row];
    end
  end

  // ----------------------------------------------------------------
  // line status
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      row_written   <= '0;
      lines_written <= '0;
      line_commit   <= 1'b0;
    end else if (ce) begin
      line_commit <= do_write;
      if (do_write) begin
        row_written[link_row] <= 1'b1;
        lines_written         <= lines_written + 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // polarity and ownership
  // ----------------------------------------------------------------
  logic [`SLI_POL_CNT_BITS-1:0] pol_age_q;
  wire  logic pol_late = (pol_age_q >= `SLI_POL_CNT_BITS'(POL_TIMEOUT_CYC));

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      panel_polarity <= 1'b0;
      pol_age_q      <= '0;
      polarity_stale <= 1'b0;
      owner_is_app   <= 1'b0;
      link_busy      <= 1'b0;
    end else if (ce) begin
      owner_is_app <= sy_q[`SLI_SY_OWNER];
      link_busy    <= sy_q[`SLI_SY_SELECT];
      if (pol_evt) begin
        panel_polarity <= ~panel_polarity;
        pol_age_q      <= '0;
        polarity_stale <= 1'b0;
      end else begin
        // saturates so a long stall never wraps back to looking healthy
        if (!pol_late) begin
          pol_age_q <= pol_age_q + `SLI_POL_CNT_BITS'(1);
        end
        polarity_stale <= pol_late;
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_line_commit: assert property (@(posedge mclk) disable iff (!resetn)
    line_evt && st_q == sli_pkg::SLI_ST_IDLE |=> st_q == sli_pkg::SLI_ST_COMMIT)
    else $error("line event not taken");

  a_commit_row: assert property (@(posedge mclk) disable iff (!resetn)
    do_write |=> line_commit && row_written[$past(link_row)])
    else $error("committed row not marked written");

  a_count_step: assert property (@(posedge mclk) disable iff (!resetn)
    do_write |=> lines_written == $past(lines_written) + 16'h0001)
    else $error("line counter missed a commit");

  a_image_hold: assert property (@(posedge mclk) disable iff (!resetn)
    !do_write |=> $stable(row_written) && $stable(lines_written))
    else $error("stored image changed without a line");

  a_commit_space: assert property (@(posedge mclk) disable iff (!resetn)
    do_write |=> !do_write ##1 !do_write)
    else $error("two rows written back to back");

  a_pol_flip: assert property (@(posedge mclk) disable iff (!resetn)
    pol_evt |=> panel_polarity != $past(panel_polarity) && !polarity_stale)
    else $error("polarity pulse not applied");

  a_owner_follow: assert property (@(posedge mclk) disable iff (!resetn)
    ce && $rose(sy_q[`SLI_SY_OWNER]) |=> owner_is_app)
    else $error("owner status did not follow");

  c_line_written: cover property (@(posedge mclk) disable iff (!resetn) do_write);
  c_two_lines:    cover property (@(posedge mclk) disable iff (!resetn)
    lines_written == 16'h0002);
  c_pol_pulse:    cover property (@(posedge mclk) disable iff (!resetn) pol_evt);
  c_owner_app:    cover property (@(posedge mclk) disable iff (!resetn) $rose(owner_is_app));

endmodule : sli_panel
`default_nettype wire

//--- sli_params.svh
// constants for the shared line-serial panel receiver
// assumes inclusion by all three design files of the panel
`ifndef SLI_PARAMS_SVH
`define SLI_PARAMS_SVH

// panel geometry
`define SLI_LINE_BITS      128
`define SLI_ROWS           128
`define SLI_ADDR_BITS      7
// one transfer: row address (msb first) then line pixels (msb first)
`define SLI_FRAME_BITS     135
`define SLI_FRAME_LAST     8'h86
`define SLI_CNT_BITS       8

// clock rates in kHz
`define SLI_MCLK_KHZ       200000
`define SLI_SCLK_MAX_KHZ   1100
// shortest link period in mclk cycles, rounded up
`define SLI_SCLK_MIN_CYC   ((`SLI_MCLK_KHZ + `SLI_SCLK_MAX_KHZ - 1) / `SLI_SCLK_MAX_KHZ)

// polarity pulse watchdog, in milliseconds
`define SLI_POL_TIMEOUT_MS 1000
`define SLI_POL_TIMEOUT_CYC (`SLI_POL_TIMEOUT_MS * `SLI_MCLK_KHZ)
`define SLI_POL_CNT_BITS   28

// synchroniser input index
`define SLI_SY_LINE        0
`define SLI_SY_POL         1
`define SLI_SY_OWNER       2
`define SLI_SY_SELECT      3
`define SLI_SY_WIDTH       4

`endif

//--- sli_pkg.sv
// types shared by the panel receiver
// assumes sli_params.svh is compiled alongside
`default_nettype none
`include "sli_params.svh"

package sli_pkg;

  typedef enum logic [1:0] {
    SLI_ST_IDLE   = 2'b01,
    SLI_ST_COMMIT = 2'b10
  } sli_state_e;

  typedef logic [`SLI_ADDR_BITS-1:0] sli_row_t;
  typedef logic [`SLI_LINE_BITS-1:0] sli_line_t;

endpackage : sli_pkg
`default_nettype wire

//--- sli_line_rx.sv
// link-side line shifter of the panel, clocked by the serial clock
// assumes the serial clock may stop whenever the select pin is low
`timescale 1ns/1ps
`default_nettype none
`include "sli_params.svh"

module sli_line_rx (
  input  wire logic                       display_serial_clock,
  input  wire logic                       resetn,
  input  wire logic                       display_select,
  input  wire logic                       display_serial_in,
  output var  logic [`SLI_ADDR_BITS-1:0]  line_row_q,
  output var  logic [`SLI_LINE_BITS-1:0]  line_data_q,
  output var  logic                       line_tgl_q
);

  // ----------------------------------------------------------------
  // bit counter
  // ----------------------------------------------------------------
  logic [`SLI_CNT_BITS-1:0]   cnt_q;
  logic [`SLI_FRAME_BITS-2:0] shift_q;
  wire  logic                 last_bit = (cnt_q == `SLI_FRAME_LAST);

  // select low clears the count with no clock edge: the clock may be stopped
  always_ff @(posedge display_serial_clock or negedge display_select or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= '0;
    end else if (!display_select) begin
      cnt_q <= '0;
    end else if (last_bit) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + `SLI_CNT_BITS'(1);
    end
  end

  always_ff @(posedge display_serial_clock) begin
    if (display_select) begin
      shift_q <= {shift_q[`SLI_FRAME_BITS-3:0], display_serial_in};
    end
  end

  // ----------------------------------------------------------------
  // line hand-off
  // ----------------------------------------------------------------
  // row and data stay put for a whole transfer, far longer than the
  // two mclk edges the toggle needs to cross
  always_ff @(posedge display_serial_clock or negedge resetn) begin
    if (!resetn) begin
      line_tgl_q  <= 1'b0;
      line_row_q  <= '0;
      line_data_q <= '0;
    end else if (display_select && last_bit) begin
      line_tgl_q  <= ~line_tgl_q;
      line_row_q  <= shift_q[`SLI_FRAME_BITS-2:`SLI_LINE_BITS-1];
      line_data_q <= {shift_q[`SLI_LINE_BITS-2:0], display_serial_in};
    end
  end

  a_count_bound: assert property (@(posedge display_serial_clock) disable iff (!resetn)
    cnt_q <= `SLI_FRAME_LAST)
    else $error("bit count past end of line");

  a_line_handoff: assert property (@(posedge display_serial_clock) disable iff (!resetn)
    display_select && last_bit |=> line_tgl_q != $past(line_tgl_q))
    else $error("full line not handed over");

  a_partial_hold: assert property (@(posedge display_serial_clock) disable iff (!resetn)
    !(display_select && last_bit) |=> $stable(line_tgl_q) && $stable(line_data_q))
    else $error("line handed over before it was complete");

endmodule : sli_line_rx
`default_nettype wire

//--- sli_host_model.sv
// partner model: the application side that drives the panel pins
// assumes the bench calls its tasks; link timing is absolute, unrelated to mclk
`timescale 1ns/1ps
`default_nettype none

module sli_host_model (
  output var logic display_serial_clock,
  output var logic display_select,
  output var logic display_serial_in,
  output var logic display_polarity_toggle,
  output var logic display_owner_select
);
  // 960 ns period keeps the link below the panel's top clock rate
  localparam time HALF = 480;

  initial begin
    display_serial_clock    = 1'b0;
    display_select          = 1'b0;
    display_serial_in       = 1'b0;
    display_polarity_toggle = 1'b0;
    display_owner_select    = 1'b0;
  end

  task automatic set_owner(input logic v);
    display_owner_select = v;
  endtask : set_owner

  task automatic open_frame;
    display_select = 1'b1;
    #HALF;
  endtask : open_frame

  // clock stands still and data goes stale once select drops
  task automatic close_frame;
    #HALF;
    display_select    = 1'b0;
    display_serial_in = ~display_serial_in;
  endtask : close_frame

  // nbits below 135 stops in mid-line
  task automatic send_line(input logic [6:0] row, input logic [127:0] data, input int nbits);
    logic [134:0] frame;
    frame = {row, data};
    for (int i = 0; i < nbits; i++) begin
      display_serial_in = frame[134 - i];
      #HALF display_serial_clock = 1'b1;
      #HALF display_serial_clock = 1'b0;
    end
  endtask : send_line

  task automatic pulse_polarity;
    display_polarity_toggle = 1'b1;
    #50 display_polarity_toggle = 1'b0;
    #50;
  endtask : pulse_polarity
endmodule : sli_host_model
`default_nettype wire

//--- tb_shared_lcd_line_interface.sv
// testbench of the panel receiver with the application model on its pins
// assumes sli_params.svh and the design files are compiled first
`timescale 1ns/1ps
`default_nettype none
`include "sli_params.svh"

module tb_shared_lcd_line_interface;
  localparam int unsigned POL_CYC = 200;
  localparam int unsigned LIMIT   = 95000;
  localparam logic [127:0] LINE_A = 128'h8000_0000_0000_0000_0000_0000_0000_0001;
  localparam logic [127:0] LINE_B = 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210;
  localparam logic [127:0] LINE_C = 128'hA5A5_0F0F_FFFF_0000_C3C3_1234_5678_9ABC;

  logic                      mclk, resetn, ce, sclk, sel, si, pol, own;
  logic [`SLI_ADDR_BITS-1:0] rd_row;
  logic [`SLI_LINE_BITS-1:0] rd_data;
  logic [`SLI_ROWS-1:0]      row_written;
  logic [15:0]               lines_written;
  logic                      line_commit, panel_polarity, polarity_stale, owner_is_app, link_busy;
  int                        fails, num_checks, commits, cyc;

  sli_panel #(.POL_TIMEOUT_CYC(POL_CYC)) i_sli_panel (
    .mclk(mclk), .resetn(resetn), .ce(ce), .display_serial_clock(sclk),
    .display_select(sel), .display_serial_in(si), .display_polarity_toggle(pol),
    .display_owner_select(own), .pixel_rd_row(rd_row), .pixel_rd_data(rd_data),
    .row_written(row_written), .lines_written(lines_written), .line_commit(line_commit),
    .panel_polarity(panel_polarity), .polarity_stale(polarity_stale),
    .owner_is_app(owner_is_app), .link_busy(link_busy));

  sli_host_model i_sli_host_model (
    .display_serial_clock(sclk), .display_select(sel), .display_serial_in(si),
    .display_polarity_toggle(pol), .display_owner_select(own));

  // ----------------------------------------------------------------
  // clock, watchdog and commit counting
  // ----------------------------------------------------------------
  initial mclk = 1'b0;
  always #2.5 mclk = ~mclk;

  always @(posedge mclk) begin
    cyc++;
    if (line_commit === 1'b1) commits++;
    if (cyc == LIMIT) begin
      fails++;
      stop_test();
    end
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick

  task automatic read_row(input logic [6:0] r, input logic [127:0] exp);
    rd_row = r;
    tick(2);
    chk(rd_data, exp);
  endtask : read_row

  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic test_reset;
    chk(row_written, '0);
    chk(lines_written, '0);
    chk(panel_polarity, 1'b0);
    chk(link_busy, 1'b0);
    $display("test_reset done");
  endtask : test_reset

  task automatic test_owner;
    i_sli_host_model.set_owner(1'b1);
    tick(4);
    chk(owner_is_app, 1'b1);
    i_sli_host_model.set_owner(1'b0);
    tick(4);
    chk(owner_is_app, 1'b0);
    i_sli_host_model.set_owner(1'b1);
    $display("test_owner done");
  endtask : test_owner

  // first and last row back to back under one select
  task automatic test_lines;
    i_sli_host_model.open_frame();
    i_sli_host_model.send_line(7'h00, LINE_A, 135);
    chk(link_busy, 1'b1);
    i_sli_host_model.send_line(7'h7F, LINE_B, 135);
    i_sli_host_model.close_frame();
    tick(20);
    chk(commits, 2);
    chk(lines_written, 16'h0002);
    chk(row_written, {1'b1, 126'h0, 1'b1});
    read_row(7'h00, LINE_A);
    read_row(7'h7F, LINE_B);
    $display("test_lines done");
  endtask : test_lines

  // a cut line leaves no trace and the next frame starts afresh
  task automatic test_abort;
    i_sli_host_model.open_frame();
    i_sli_host_model.send_line(7'h05, LINE_B, 40);
    i_sli_host_model.close_frame();
    tick(20);
    chk(commits, 2);
    chk(row_written[5], 1'b0);
    i_sli_host_model.open_frame();
    i_sli_host_model.send_line(7'h05, LINE_C, 135);
    i_sli_host_model.close_frame();
    tick(20);
    chk(lines_written, 16'h0003);
    read_row(7'h05, LINE_C);
    read_row(7'h00, LINE_A);
    $display("test_abort done");
  endtask : test_abort

  task automatic test_polarity;
    chk(polarity_stale, 1'b1);
    i_sli_host_model.pulse_polarity();
    tick(1);
    chk(panel_polarity, 1'b1);
    chk(polarity_stale, 1'b0);
    tick(POL_CYC + 20);
    chk(polarity_stale, 1'b1);
    i_sli_host_model.pulse_polarity();
    tick(1);
    chk(panel_polarity, 1'b0);
    chk(polarity_stale, 1'b0);
    read_row(7'h7F, LINE_B);
    $display("test_polarity done");
  endtask : test_polarity

  // a low enable freezes every mclk-side register, so a pulse then is lost
  task automatic test_enable;
    ce     = 1'b0;
    rd_row = 7'h05;
    i_sli_host_model.pulse_polarity();
    tick(2);
    chk(panel_polarity, 1'b0);
    chk(rd_data, LINE_B);
    ce = 1'b1;
    tick(4);
    chk(panel_polarity, 1'b0);
    chk(rd_data, LINE_C);
    $display("test_enable done");
  endtask : test_enable

  initial begin
    ce     = 1'b1;
    rd_row = '0;
    // a short wait lets every process see the falling reset edge
    #1 resetn = 1'b0;
    tick(2);
    resetn = 1'b1;
    tick(1);
    test_reset();
    test_owner();
    test_lines();
    test_abort();
    test_polarity();
    test_enable();
    stop_test();
  end
endmodule : tb_shared_lcd_line_interface
`default_nettype wire
